// ==== mac_model.sv ====
// Behavioural MAC capturing the receive pins
`timescale 1ns/10ps
module mac_model (
	input wire rx_pkg::pins_t pins,
	output logic [9:0] rise_w,
	output logic [4:0] fall_w,
	output logic [9:0] even_w
);
	import rx_pkg::*;
	// Undriven lines read inverted so a released bus never looks right
	wire [9:0] r = {pins.aux9, pins.aux8, pins.d};
	wire [9:0] e = {pins.aux9_oe, pins.aux8_oe, {4{pins.hi_oe}}, {4{pins.lo_oe}}};
	wire [9:0] v = r ^ ~e;
	wire ck = pins.tbi_odd_group_clock & pins.odd_clk_oe;
	wire ev = pins.tbi_even_group_clock & pins.even_clk_oe;
	always @(posedge ck) rise_w <= v;
	always @(negedge ck) fall_w <= {v[8], v[3:0]};
	always @(posedge ev) even_w <= v;
endmodule

// ==== rx_cfg.svh ====
// Constants for the parallel MAC receive output block
`ifndef RX_CFG_SVH
`define RX_CFG_SVH
// ==========================================
// Timing
// Quarter of an output slot in ref_clk cycles; four quarters match one
// recovered clock period (320 ns at 40 ns).
`define RX_QTR_LAST 2'h1
`define RX_QTR_FIRST 2'h0
`define RX_QTR_STEP 2'h1
// ==========================================
// Buffer
`define RX_BUF_FULL 2'h2
`define RX_BUF_EMPTY 2'h0
// ==========================================
// Code group fields
`define CG_LO 3:0
`define CG_HI 7:4
`define CG_BYTE 7:0
`define CG_RTBI_HI 8:5
`define CG_B4 4
`define CG_B8 8
`define CG_B9 9
`define PIN_LO 3:0
`define PIN_HI 7:4
`endif

// ==== rx_mac_out.sv ====
// Receive direction of the parallel MAC port: TBI, RTBI, GMII, MII, RGMII
`timescale 1ns/10ps
`include "rx_cfg.svh"
module rx_mac_out (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [2:0] mode_sel,
	input wire logic drive_en,
	input wire rx_pkg::line_t line_in,
	output logic src_ready,
	output rx_pkg::pins_t pins
);
	import rx_pkg::*;

	state_t s;
	state_t n;
	logic edge_seen;
	logic go;
	logic take;
	logic push;
	logic qdone;
	word_t head;

	// ==========================================
	// Helpers
	function automatic logic is_tbi(input logic [2:0] m);
		is_tbi = (m == MODE_TBI);
	endfunction

	function automatic logic late_half(input phase_t p);
		late_half = (p == PH_Q2) || (p == PH_Q3);
	endfunction

	function automatic logic mid_half(input phase_t p);
		mid_half = (p == PH_Q1) || (p == PH_Q2);
	endfunction

	// Pin values for one quarter of a slot
	function automatic pins_t drive_pins(input logic [2:0] m, input phase_t p, input word_t w,
			input logic ev, input logic st, input logic en);
		pins_t o;
		o = '0;
		case (m)
			MODE_TBI: begin
				o.d[`PIN_LO] = w.code[`CG_LO];
				o.d[`PIN_HI] = w.code[`CG_HI];
				o.aux8 = w.code[`CG_B8];
				o.aux9 = w.code[`CG_B9];
				// Each clock is high in the middle of its own slot only, so
				// rising edges are half a clock period apart
				o.tbi_odd_group_clock = !st && !ev && mid_half(p);
				o.tbi_even_group_clock = !st && ev && mid_half(p);
				o.lo_oe = en;
				o.hi_oe = en;
				o.aux8_oe = en;
				o.aux9_oe = en;
				o.odd_clk_oe = en;
				o.even_clk_oe = en;
			end
			MODE_RTBI: begin
				o.d[`PIN_LO] = late_half(p) ? w.code[`CG_RTBI_HI] : w.code[`CG_LO];
				o.aux8 = late_half(p) ? w.code[`CG_B9] : w.code[`CG_B4];
				o.tbi_odd_group_clock = mid_half(p);
				o.lo_oe = en;
				o.aux8_oe = en;
				o.odd_clk_oe = en;
			end
			MODE_GMII: begin
				o.d = w.code[`CG_BYTE];
				o.aux8 = w.dv;
				o.tbi_odd_group_clock = late_half(p);
				o.lo_oe = en;
				o.hi_oe = en;
				o.aux8_oe = en;
				o.odd_clk_oe = en;
			end
			MODE_MII: begin
				o.d[`PIN_LO] = w.code[`CG_LO];
				o.aux8 = w.dv;
				o.tbi_odd_group_clock = late_half(p);
				o.lo_oe = en;
				o.aux8_oe = en;
				o.odd_clk_oe = en;
			end
			MODE_RGMII: begin
				o.d[`PIN_LO] = late_half(p) ? w.code[`CG_HI] : w.code[`CG_LO];
				o.tbi_odd_group_clock = mid_half(p);
				o.lo_oe = en;
				o.odd_clk_oe = en;
			end
			default: begin
				o = '0;
			end
		endcase
		return o;
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		n = s;
		go = 1'b0;
		take = 1'b0;
		n.l1 = line_in;
		n.l2 = s.l1;
		n.clk_d = s.l2.clk;
		n.mode1 = mode_sel;
		n.mode2 = s.mode1;
		n.oe1 = drive_en;
		n.oe2 = s.oe1;
		// Recovered clock rise paces the slots, so the output clocks follow it
		edge_seen = s.l2.clk & ~s.clk_d;
		qdone = (s.qcnt == `RX_QTR_LAST);
		head = s.fifo[s.rd_ptr];
		push = edge_seen && (s.count != `RX_BUF_FULL);

		if (s.phase == PH_WAIT) begin
			go = s.pending;
		end else if (s.phase == PH_Q3 && qdone) begin
			go = s.pending;
		end

		if (s.phase != PH_WAIT) begin
			n.qcnt = qdone ? `RX_QTR_FIRST : s.qcnt + `RX_QTR_STEP;
			if (qdone) begin
				unique case (s.phase)
					PH_Q0: n.phase = PH_Q1;
					PH_Q1: n.phase = PH_Q2;
					PH_Q2: n.phase = PH_Q3;
					PH_Q3: n.phase = PH_WAIT;
					PH_WAIT: n.phase = PH_WAIT;
				endcase
			end
		end

		if (go) begin
			n.phase = PH_Q0;
			n.qcnt = `RX_QTR_FIRST;
			n.slot_even = s.even_next;
			// A comma due on an odd slot waits one idle slot: both clocks hold
			// their level, so periods only grow
			if (is_tbi(s.mode_cur) && s.count != `RX_BUF_EMPTY && s.l2.aligned
					&& head.comma && !s.even_next) begin
				n.stretch = 1'b1;
				n.even_next = 1'b1;
			end else begin
				n.stretch = 1'b0;
				take = (s.count != `RX_BUF_EMPTY);
				n.cur = take ? head : '0;
				if (is_tbi(s.mode_cur)) begin
					n.even_next = ~s.even_next;
				end
			end
		end

		// New edge wins over the consumption of the old one
		n.pending = edge_seen | (s.pending & ~go);

		if (push) begin
			n.fifo[s.wr_ptr] = '{code: s.l2.code, dv: s.l2.valid, comma: s.l2.comma};
			n.wr_ptr = ~s.wr_ptr;
		end
		if (take) begin
			n.rd_ptr = ~s.rd_ptr;
		end
		n.count = s.count + {1'b0, push} - {1'b0, take};

		if (n.phase != PH_WAIT) begin
			n.pins = drive_pins(s.mode_cur, n.phase, n.cur, n.slot_even, n.stretch, s.oe2);
		end else begin
			n.pins = drive_pins(s.mode_cur, s.phase, s.cur, s.slot_even, s.stretch, s.oe2);
		end

		// Mode change restarts cleanly; a half-sent word would confuse the MAC
		if (s.mode2 != s.mode_cur) begin
			n.mode_cur = s.mode2;
			n.fifo = '0;
			n.wr_ptr = 1'b0;
			n.rd_ptr = 1'b0;
			n.count = `RX_BUF_EMPTY;
			n.phase = PH_WAIT;
			n.qcnt = `RX_QTR_FIRST;
			n.pending = 1'b0;
			n.even_next = 1'b0;
			n.slot_even = 1'b0;
			n.stretch = 1'b0;
			n.cur = '0;
			n.pins = '0;
		end
		n.src_ready = (n.count != `RX_BUF_FULL);
	end

	// ==========================================
	// State register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign src_ready = s.src_ready;
	assign pins = s.pins;
endmodule

// ==== rx_mac_out_props.sv ====
// Checker for the receive output block
`timescale 1ns/10ps
module rx_mac_out_props (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [2:0] mode_sel,
	input wire logic drive_en,
	input wire rx_pkg::line_t line_in,
	input wire logic src_ready,
	input wire rx_pkg::pins_t pins
);
	import rx_pkg::*;
	wire oclk = pins.tbi_odd_group_clock;
	wire eclk = pins.tbi_even_group_clock;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ====
	// Clock shape
	property p_no_short; $rose(oclk) |-> oclk [*4]; endproperty
	a_no_short: assert property (p_no_short) else $error("clock high cut short");
	property p_low_min; $fell(oclk) |-> !oclk [*4]; endproperty
	a_low_min: assert property (p_low_min) else $error("clock low cut short");
	property p_excl; !(oclk && eclk); endproperty
	a_excl: assert property (p_excl) else $error("both group clocks high");
	// Alignment may stretch a slot, so the fixed spacing holds only while unaligned
	property p_even_after; (mode_sel == MODE_TBI && !line_in.aligned) [*8] ##0 $rose(oclk)
		|-> ##8 $rose(eclk);
	endproperty
	a_even_after: assert property (p_even_after) else $error("even clock not opposite");
	property p_even_idle; (mode_sel != MODE_TBI) [*8] |-> !eclk; endproperty
	a_even_idle: assert property (p_even_idle) else $error("even clock outside group mode");
	// ====
	// Data against clock
	property p_rise_hold; $rose(oclk) |-> $stable({pins.d, pins.aux8}) [*2]; endproperty
	a_rise_hold: assert property (p_rise_hold) else $error("data moved at rise");
	property p_fall_hold; (mode_sel == MODE_RGMII || mode_sel == MODE_RTBI) [*8] ##0 $fell(oclk)
		|-> $stable({pins.d[3:0], pins.aux8}) [*2]; endproperty
	a_fall_hold: assert property (p_fall_hold) else $error("data moved at fall");
	// ====
	// Drivers
	property p_oe_off; !drive_en [*6] |-> !pins.lo_oe && !pins.odd_clk_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("pins driven while disabled");
	property p_gmii_on; (drive_en && mode_sel == MODE_GMII) [*6]
		|-> pins.lo_oe && pins.hi_oe && pins.odd_clk_oe; endproperty
	a_gmii_on: assert property (p_gmii_on) else $error("byte lanes or clock undriven");
endmodule
bind rx_mac_out rx_mac_out_props rx_mac_out_props_inst (.ref_clk, .reset_n, .ce, .mode_sel,
	.drive_en, .line_in, .src_ready, .pins);

// ==== rx_pkg.sv ====
// Types for the parallel MAC receive output block
package rx_pkg;
	// ==========================================
	// Modes and slot phases
	typedef enum logic [2:0] {
		MODE_TBI = 3'b000,
		MODE_RTBI = 3'b001,
		MODE_GMII = 3'b010,
		MODE_MII = 3'b011,
		MODE_RGMII = 3'b100
	} mode_t;
	typedef enum logic [2:0] {
		PH_WAIT = 3'b000,
		PH_Q0 = 3'b001,
		PH_Q1 = 3'b010,
		PH_Q2 = 3'b011,
		PH_Q3 = 3'b100
	} phase_t;
	// ==========================================
	// Carriers
	typedef struct packed {
		logic clk;
		logic valid;
		logic comma;
		logic aligned;
		logic [9:0] code;
	} line_t;
	typedef struct packed {
		logic [9:0] code;
		logic dv;
		logic comma;
	} word_t;
	typedef struct packed {
		logic [7:0] d;
		logic aux8;
		logic aux9;
		logic tbi_odd_group_clock;
		logic tbi_even_group_clock;
		logic lo_oe;
		logic hi_oe;
		logic aux8_oe;
		logic aux9_oe;
		logic odd_clk_oe;
		logic even_clk_oe;
	} pins_t;
	// ==========================================
	// Whole state of the block
	typedef struct packed {
		line_t l1;
		line_t l2;
		logic clk_d;
		logic [2:0] mode1;
		logic [2:0] mode2;
		logic [2:0] mode_cur;
		logic oe1;
		logic oe2;
		word_t [1:0] fifo;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
		phase_t phase;
		logic [1:0] qcnt;
		logic pending;
		logic even_next;
		logic slot_even;
		logic stretch;
		word_t cur;
		pins_t pins;
		logic src_ready;
	} state_t;
endpackage

// ==== tb.sv ====
// Testbench for the receive output block
`timescale 1ns/10ps
module tb;
	import rx_pkg::*;
	logic ref_clk, reset_n, ce, drive_en, src_ready;
	logic [2:0] mode_sel;
	line_t line_in;
	pins_t pins;
	logic [9:0] rise_w, even_w, k;
	logic [4:0] fall_w;
	int failures, n_compared, cycles;
	rx_mac_out rx_mac_out_inst (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
		.mode_sel(mode_sel), .drive_en(drive_en), .line_in(line_in), .src_ready(src_ready),
		.pins(pins));
	mac_model mac_model_inst (.pins(pins), .rise_w(rise_w), .fall_w(fall_w), .even_w(even_w));
	// ====
	// Clocks, recovered line stream, watchdog
	initial begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		line_in = '0;
		k = 0;
		#13;
		forever begin
			#160 line_in.clk = 1;
			#160 line_in.clk = 0;
			k = k + 10'h1;
			line_in.code = k;
			line_in.valid = k[0];
			line_in.comma = k[2:0] == 3'h5;
		end
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			summarize;
		end
	end
	// ====
	// Helpers
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	task check(input logic [9:0] seen, input logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ====
	// Scenarios
	task t_drive;
		tick(8);
		check(pins.lo_oe | pins.odd_clk_oe, 10'h0);
		drive_en = 1;
		tick(8);
		check(pins.odd_clk_oe, 10'h1);
		check(src_ready, 10'h1);
	endtask
	// Consecutive words must count up, so lane order and loss both show
	task t_stream(input mode_t m);
		logic [9:0] w, p, mk;
		mode_sel = m;
		mk = m == MODE_MII ? 10'hf : m == MODE_RTBI ? 10'h3ff : 10'hff;
		tick(40);
		for (int i = 0; i < 9; i++) begin
			@(negedge pins.tbi_odd_group_clock);
			tick(1);
			case (m)
				MODE_RGMII: w = {2'h0, fall_w[3:0], rise_w[3:0]};
				MODE_RTBI: w = {fall_w, rise_w[8], rise_w[3:0]};
				default: w = rise_w & mk;
			endcase
			if (i > 0) check((w - p) & mk, 10'h1);
			if (m == MODE_GMII || m == MODE_MII) check(rise_w[8], rise_w[0]);
			p = w;
		end
	endtask
	task t_tbi;
		mode_sel = MODE_TBI;
		tick(40);
		repeat (6) begin
			@(posedge pins.tbi_even_group_clock);
			tick(1);
			check(even_w, rise_w + 10'h1);
		end
		line_in.aligned = 1;
		repeat (30) begin
			@(posedge pins.tbi_odd_group_clock);
			tick(1);
			check(rise_w[2:0] == 3'h5, 10'h0);
		end
	endtask
	initial begin
		reset_n = 0;
		ce = 1;
		drive_en = 0;
		mode_sel = MODE_GMII;
		tick(16);
		reset_n = 1;
		t_drive;
		t_stream(MODE_GMII);
		t_stream(MODE_MII);
		t_stream(MODE_RGMII);
		t_stream(MODE_RTBI);
		t_tbi;
		summarize;
	end
endmodule
